//--- hdl/adc_seq_pkg.sv
// Register map, field layout and constants of the conversion start sequencer
package adc_seq_pkg;
	localparam logic [7:0] OFF_BASE_CLOCK = 8'h0C;
	localparam logic [7:0] OFF_PERIOD_DIV = 8'h10;
	localparam logic [7:0] OFF_SCAN_DIV = 8'h14;
	localparam logic [7:0] OFF_CHAN_GAIN = 8'h18;
	localparam logic [7:0] OFF_FAF_THRESH = 8'h20;
	localparam logic [7:0] OFF_FIFO_COUNT = 8'h28;
	localparam logic [7:0] OFF_FIFO_DATA = 8'h30;
	localparam logic [7:0] OFF_ACQ_CTRL = 8'h38;
	localparam logic [7:0] OFF_IRQ = 8'h40;
	// Control register fields
	localparam int CTRL_START_BIT = 16;
	localparam int CTRL_SCAN_BIT = 18;
	localparam int CTRL_GAIN_LSB = 0;
	localparam int CTRL_CHAN_LSB = 4;
	localparam int CTRL_MODE_LSB = 8;
	// Interrupt register fields
	localparam int IRQ_FAF_EN_BIT = 0;
	localparam int IRQ_FAF_STAT_BIT = 16;
	// Reset values
	localparam logic [31:0] RST_DIV = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_GAIN = 32'h0000_0000;
	localparam logic [31:0] RST_FAF = 32'h0000_0000;
	// Base clock figure, 200 MHz
	localparam logic [31:0] BASE_CLOCK_HZ = 32'h0BEB_C200;
	// Sequencer modes
	localparam logic [1:0] MODE_NONSEQ = 2'h0;
	localparam logic [1:0] MODE_MODIFY = 2'h1;
	localparam logic [1:0] MODE_ADVANCED = 2'h2;
	localparam logic [1:0] MODE_BASIC = 2'h3;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_SCAN = 2'b10
	} seq_state_t;
endpackage

//--- hdl/adc_start_scan_sequencer.sv
// Conversion start sequencer: start sources, scan walk, sample FIFO, regs
//
// Overview of operation
// [R1] Zero divisor: start bit gives one event
// [R2] Divisor, no trigger: start now, then periodic
// [R3] Divisor with trigger: start bit only arms
// [R4] Triggered timer runs until start bit cleared
// [R5] External start edge gives one event each
// [R6] Scan bit clear: one channel per event
// [R7] Scan bit set: channel 0 to last channel
// [R8] In-scan spacing uses in-scan divisor
// [R9] Scan bit ignored in non-sequenced or channel 0
// [R10] Event rate is base clock over divisor
// [R11] Read-only register gives base clock hertz
// [R12] Gain register holds one nybble per channel
// [R13] Host accesses are full 32-bit words
// [R14] Interrupt when FIFO reaches threshold, if enabled
// [R15] Count register; data read pops sample
// [R16] Host avoids undefined register addresses
// [R17] Non-sequenced uses last channel, common gain
// [R18] Sequenced modes step channels, wrap to 0
// [R19] First scan channel converts at once
// [R20] Start during a scan is ignored
`timescale 1ns/10ps
module adc_start_scan_sequencer
#(
	parameter int FIFO_DEPTH = 32768,
	parameter int CNT_W = 16
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port, full words only
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// Trigger inputs and their enables
	input wire logic trig_in,
	input wire logic trig_en,
	input wire logic trig_rising,
	input wire logic ext_start_in,
	input wire logic ext_start_en,
	input wire logic ext_start_rising,
	// Converter command and result
	output logic conv_start,
	output logic [2:0] conv_channel,
	output logic [3:0] conv_gain,
	input wire logic conv_done,
	input wire logic [31:0] conv_data,
	// Interrupt request level
	output logic irq
);
	import adc_seq_pkg::*;

	localparam int AW = $clog2(FIFO_DEPTH);

	logic [31:0] period_div_reg; // Periodic start divisor
	logic [31:0] scan_div_reg; // In-scan divisor
	logic [31:0] gain_reg; // Per-channel gain nybbles
	logic [31:0] faf_reg; // Almost-full level
	logic [31:0] ctrl_reg; // Acquisition control
	logic faf_en_reg; // Interrupt enable
	logic faf_stat_reg; // Sticky interrupt latch
	logic running_reg; // Periodic timer active
	logic armed_reg; // Waiting for trigger edge
	logic trig_q_reg; // Previous trigger level
	logic ext_q_reg; // Previous external start level
	seq_state_t state_reg; // Scan walker state
	logic [2:0] chan_reg; // Next channel of the scan
	logic [2:0] rot_reg; // Rotating channel outside scans
	logic [31:0] mem [FIFO_DEPTH]; // Sample storage
	logic [AW-1:0] wptr_reg; // Write pointer
	logic [AW-1:0] rptr_reg; // Read pointer
	logic [CNT_W:0] count_reg; // Samples held
	logic [31:0] head_reg; // Sample shown at data register

	logic ctrl_wr; // Control register write
	logic [31:0] ctrl_now; // Control as it stands this cycle
	logic start_wr; // Control write with start bit
	logic [1:0] mode; // Sequencer mode field
	logic [2:0] last_chan; // Last channel field
	logic scan_mode; // Effective scan bit
	logic period_tick; // Periodic timeout
	logic scan_tick; // In-scan timeout
	logic trig_edge; // Configured trigger edge seen
	logic ext_edge; // Configured external start edge seen
	logic start_event; // Any start source
	logic fifo_push; // Store a sample
	logic fifo_pop; // Data register read
	logic fifo_full; // No room left
	logic fifo_empty; // Nothing held

	// Pick nybble n of a packed gain word
	function automatic logic [3:0] nyb(input logic [31:0] w,
		input logic [2:0] n);
		nyb = w[{n, 2'b00} +: 4];
	endfunction

	// Edge detect with selectable polarity
	function automatic logic edge_of(input logic now, input logic prev,
		input logic rising);
		edge_of = rising ? (now & ~prev) : (~now & prev);
	endfunction

	assign ctrl_wr = reg_wr && reg_addr == OFF_ACQ_CTRL;
	assign start_wr = ctrl_wr && reg_wdata[CTRL_START_BIT];
	// A start write converts with the fields it carries, not the old ones
	assign ctrl_now = ctrl_wr ? reg_wdata : ctrl_reg;
	assign mode = ctrl_now[CTRL_MODE_LSB +: 2];
	assign last_chan = ctrl_now[CTRL_CHAN_LSB +: 3];
	// Scan bit forced off when it cannot mean anything
	assign scan_mode = ctrl_now[CTRL_SCAN_BIT] && mode != MODE_NONSEQ
		&& last_chan != 3'h0; // [R9]
	assign trig_edge = trig_en && edge_of(trig_in, trig_q_reg, trig_rising);
	assign ext_edge = ext_start_en
		&& edge_of(ext_start_in, ext_q_reg, ext_start_rising); // [R5]
	assign fifo_full = count_reg == (CNT_W + 1)'(FIFO_DEPTH);
	assign fifo_empty = count_reg == '0;
	assign fifo_push = conv_done && !fifo_full;
	assign fifo_pop = reg_rd && reg_addr == OFF_FIFO_DATA && !fifo_empty;

	// Start sources merged; a write with the divisor zero fires once
	always_comb
	begin
		start_event = ext_edge; // [R5]
		if (start_wr && !(period_div_reg != '0 && trig_en))
			start_event = 1'b1; // [R1] [R2]
		if (period_tick && running_reg)
			start_event = 1'b1; // [R2] [R10]
		if (armed_reg && trig_edge)
			start_event = 1'b1; // [R3]
	end

	// Periodic timer at base clock over divisor
	rate_divider u_period
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(running_reg),
		.restart(start_wr || (armed_reg && trig_edge)),
		.divisor(period_div_reg),
		.tick(period_tick)
	); // [R10]

	// Spacing between channels inside a scan
	rate_divider u_scan
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(state_reg == SEQ_SCAN),
		.restart(1'b0),
		.divisor(scan_div_reg),
		.tick(scan_tick)
	); // [R8]

	// Software-writable registers
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			period_div_reg <= RST_DIV;
			scan_div_reg <= RST_DIV;
			gain_reg <= RST_GAIN;
			faf_reg <= RST_FAF;
			ctrl_reg <= RST_CTRL;
			faf_en_reg <= 1'b0;
		end
		else if (reg_wr)
		begin
			// Whole-word writes only; no byte lanes exist
			case (reg_addr) // [R13]
				OFF_PERIOD_DIV: period_div_reg <= reg_wdata;
				OFF_SCAN_DIV: scan_div_reg <= reg_wdata;
				OFF_CHAN_GAIN: gain_reg <= reg_wdata; // [R12]
				OFF_FAF_THRESH: faf_reg <= reg_wdata;
				OFF_ACQ_CTRL: ctrl_reg <= reg_wdata;
				OFF_IRQ: faf_en_reg <= reg_wdata[IRQ_FAF_EN_BIT];
				default: ; // Undefined offsets ignore writes
			endcase
		end
	end

	// Periodic run and arm state
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			running_reg <= 1'b0;
			armed_reg <= 1'b0;
		end
		else if (ctrl_wr && !reg_wdata[CTRL_START_BIT])
		begin
			// Clearing the start bit stops timer and disarms
			running_reg <= 1'b0; // [R4]
			armed_reg <= 1'b0;
		end
		else if (start_wr)
		begin
			// Divisor zero is a one-shot, nothing keeps running
			running_reg <= period_div_reg != '0 && !trig_en; // [R1] [R2]
			armed_reg <= period_div_reg != '0 && trig_en; // [R3]
		end
		else if (armed_reg && trig_edge)
		begin
			// Once fired, runs free of further edges
			running_reg <= 1'b1; // [R4]
			armed_reg <= 1'b0;
		end
	end

	// Input history for edge detection
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			trig_q_reg <= 1'b0;
			ext_q_reg <= 1'b0;
		end
		else
		begin
			trig_q_reg <= trig_in;
			ext_q_reg <= ext_start_in;
		end
	end

	// Channel walker and conversion command
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= SEQ_IDLE;
			chan_reg <= 3'h0;
			rot_reg <= 3'h0;
			conv_start <= 1'b0;
			conv_channel <= 3'h0;
			conv_gain <= 4'h0;
		end
		else
		begin
			conv_start <= 1'b0;
			case (state_reg)
				SEQ_IDLE:
				begin
					if (start_event && scan_mode)
					begin
						// First channel converts on the event itself
						conv_start <= 1'b1; // [R19] [R7]
						conv_channel <= 3'h0;
						conv_gain <= mode == MODE_ADVANCED ?
							nyb(gain_reg, 3'h0) :
							ctrl_now[CTRL_GAIN_LSB +: 4];
						chan_reg <= 3'h1;
						state_reg <= SEQ_SCAN;
					end
					else if (start_event)
					begin
						conv_start <= 1'b1; // [R6]
						if (mode == MODE_NONSEQ)
						begin
							conv_channel <= last_chan; // [R17]
							conv_gain <= ctrl_now[CTRL_GAIN_LSB +: 4];
						end
						else
						begin
							// Sequenced step, wrap after last channel
							conv_channel <= rot_reg; // [R18]
							conv_gain <= mode == MODE_ADVANCED ?
								nyb(gain_reg, rot_reg) :
								ctrl_now[CTRL_GAIN_LSB +: 4];
							rot_reg <= rot_reg >= last_chan ?
								3'h0 : rot_reg + 3'h1;
						end
					end
				end
				SEQ_SCAN:
				begin
					// New start events are dropped here
					if (scan_tick) // [R8] [R20]
					begin
						conv_start <= 1'b1;
						conv_channel <= chan_reg;
						conv_gain <= mode == MODE_ADVANCED ?
							nyb(gain_reg, chan_reg) :
							ctrl_now[CTRL_GAIN_LSB +: 4];
						chan_reg <= chan_reg + 3'h1;
						if (chan_reg >= last_chan)
							state_reg <= SEQ_IDLE; // [R7]
					end
					else if (!scan_mode)
						state_reg <= SEQ_IDLE;
				end
				default: state_reg <= SEQ_IDLE;
			endcase
		end
	end

	// Sample memory write, no reset on storage
	always_ff @(posedge sys_clk)
	begin
		if (fifo_push)
			mem[wptr_reg] <= conv_data;
	end

	// Pointers, count and head word
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
			head_reg <= 32'h0000_0000;
		end
		else
		begin
			if (fifo_push)
				wptr_reg <= wptr_reg + AW'(1);
			if (fifo_pop)
				rptr_reg <= rptr_reg + AW'(1); // [R15]
			if (fifo_push && !fifo_pop)
				count_reg <= count_reg + (CNT_W + 1)'(1);
			else if (fifo_pop && !fifo_push)
				count_reg <= count_reg - (CNT_W + 1)'(1);
			head_reg <= mem[rptr_reg];
		end
	end

	// Almost-full latch: set wins over a same-cycle clear
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			faf_stat_reg <= 1'b0;
		else if (faf_en_reg && 32'(count_reg) >= faf_reg)
			faf_stat_reg <= 1'b1; // [R14]
		else if (reg_wr && reg_addr == OFF_IRQ
			&& reg_wdata[IRQ_FAF_STAT_BIT])
			faf_stat_reg <= 1'b0;
	end

	assign irq = faf_stat_reg && faf_en_reg; // [R14]

	// Read mux, registered; undefined offsets read zero
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				OFF_BASE_CLOCK: reg_rdata <= BASE_CLOCK_HZ; // [R11]
				OFF_PERIOD_DIV: reg_rdata <= period_div_reg;
				OFF_SCAN_DIV: reg_rdata <= scan_div_reg;
				OFF_CHAN_GAIN: reg_rdata <= gain_reg;
				OFF_FAF_THRESH: reg_rdata <= faf_reg;
				OFF_FIFO_COUNT: reg_rdata <= 32'(count_reg); // [R15]
				OFF_FIFO_DATA: reg_rdata <= fifo_empty ? 32'h0000_0000
					: head_reg;
				OFF_ACQ_CTRL: reg_rdata <= ctrl_reg;
				OFF_IRQ: reg_rdata <= {15'h0000, faf_stat_reg,
					15'h0000, faf_en_reg};
				default: reg_rdata <= 32'h0000_0000; // [R16]
			endcase
		end
	end
endmodule

//--- hdl/rate_divider.sv
// Programmable divider that emits one-cycle timeout pulses
`timescale 1ns/10ps
module rate_divider
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [31:0] divisor,
	// Timeout pulse
	output logic tick
);
	logic [31:0] count_reg; // Cycles since last timeout

	// Pulse while the count sits on the divisor, so the first timeout
	// after a restart is exactly one period away, not one more
	assign tick = run && !restart && divisor != 32'h0000_0000
		&& count_reg >= divisor;

	// Counts divisor cycles; restart realigns phase
	// A zero divisor never times out, callers must guard it
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			count_reg <= 32'h0000_0000;
		else if (!run || restart || divisor == 32'h0000_0000)
			count_reg <= 32'h0000_0001;
		else if (tick)
			// Guard with >= so a shrunk divisor never stalls the wrap
			count_reg <= 32'h0000_0001;
		else
			count_reg <= count_reg + 32'h0000_0001;
	end
endmodule

//--- verif/adc_seq_checker.sv
// Checker for the conversion start sequencer, bound to its top
`timescale 1ns/10ps
module adc_seq_checker
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// Trigger enables
	input wire logic trig_en,
	input wire logic ext_start_en,
	// Converter command and interrupt
	input wire logic conv_start,
	input wire logic [2:0] conv_channel,
	input wire logic [3:0] conv_gain,
	input wire logic irq
);
	// Shadows of what the host wrote
	logic [31:0] ctrl_reg;
	logic [31:0] per_reg;
	logic [31:0] gain_reg;
	logic ctrl_wr;
	logic start_wr;
	assign ctrl_wr = reg_wr && reg_addr == OFF_ACQ_CTRL;
	// Start from a stopped state only; a rewrite mid-scan is ignored
	assign start_wr = ctrl_wr && reg_wdata[CTRL_START_BIT] &&
		!ctrl_reg[CTRL_START_BIT] && !trig_en;
	// Control shadow
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_reg <= RST_CTRL;
		else if (ctrl_wr)
			ctrl_reg <= reg_wdata;
	end
	// Divisor and gain shadows
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			per_reg <= RST_DIV;
			gain_reg <= RST_GAIN;
		end
		else if (reg_wr && reg_addr == OFF_PERIOD_DIV)
			per_reg <= reg_wdata;
		else if (reg_wr && reg_addr == OFF_CHAN_GAIN)
			gain_reg <= reg_wdata;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	base_clock_a: assert property (
		reg_rd && reg_addr == OFF_BASE_CLOCK |=> reg_rdata == BASE_CLOCK_HZ)
		else $error("base clock read wrong");
	unmapped_read_a: assert property (
		reg_rd && reg_addr == 8'h3C |=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	gain_read_a: assert property (
		reg_rd && reg_addr == OFF_CHAN_GAIN |=> reg_rdata == gain_reg)
		else $error("gain read back wrong");
	period_read_a: assert property (
		reg_rd && reg_addr == OFF_PERIOD_DIV |=> reg_rdata == per_reg)
		else $error("period read back wrong");
	rdata_hold_a: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	single_start_a: assert property (
		start_wr && reg_wdata[9:8] == MODE_NONSEQ && per_reg == 32'h0 &&
		!ext_start_en |=> conv_start ##1 !conv_start [*8])
		else $error("single start not exactly one");
	scan_first_a: assert property (
		start_wr && reg_wdata[CTRL_SCAN_BIT] && reg_wdata[9:8] != 2'h0 &&
		reg_wdata[6:4] != 3'h0 |=> conv_start && conv_channel == 3'h0)
		else $error("scan did not open on channel 0");
	nonseq_chan_a: assert property (
		conv_start && ctrl_reg[9:8] == MODE_NONSEQ |->
		conv_channel == ctrl_reg[6:4] && conv_gain == ctrl_reg[3:0])
		else $error("non-sequenced channel or gain wrong");
	adv_gain_a: assert property (
		conv_start && ctrl_reg[9:8] == MODE_ADVANCED |->
		conv_gain == gain_reg[{conv_channel, 2'b00} +: 4])
		else $error("per-channel gain not applied");
	irq_mask_a: assert property (
		reg_wr && reg_addr == OFF_IRQ && !reg_wdata[IRQ_FAF_EN_BIT] |=> !irq)
		else $error("interrupt seen while disabled");
endmodule
bind adc_start_scan_sequencer adc_seq_checker chk (
	.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .trig_en(trig_en), .ext_start_en(ext_start_en),
	.conv_start(conv_start), .conv_channel(conv_channel),
	.conv_gain(conv_gain), .irq(irq));

//--- verif/conv_model.sv
// Behavioural converter answering each start after a set delay
`timescale 1ns/10ps
module conv_model
#(
	parameter int DLY = 3
)
(
	// Clock
	input wire logic sys_clk,
	// Start command
	input wire logic conv_start,
	input wire logic [2:0] conv_channel,
	input wire logic [3:0] conv_gain,
	// Result
	output logic conv_done,
	output logic [31:0] conv_data
);
	initial
	begin
		conv_done = 1'b0;
		conv_data = 32'h00000000;
	end
	// Sample word carries channel and gain so the bench can trace it
	task automatic answer(input logic [6:0] v);
		repeat (DLY) @(posedge sys_clk);
		#1 conv_done = 1'b1;
		conv_data = {25'h0000000, v};
		@(posedge sys_clk);
		#1 conv_done = 1'b0;
		// Released bus shows the inverse, never a stale copy
		conv_data = ~conv_data;
	endtask
	// Each start spawns its own answer, so overlap is tolerated
	always @(posedge sys_clk)
		if (conv_start === 1'b1)
			fork
				answer({conv_channel, conv_gain});
			join_none
endmodule

//--- verif/tb_adc_start_scan_sequencer.sv
// Self-checking bench for the conversion start sequencer
`timescale 1ns/10ps
module tb_adc_start_scan_sequencer;
	import adc_seq_pkg::*;
	logic sys_clk, resetn, reg_wr, reg_rd, conv_done, irq, conv_start;
	logic trig_in, trig_en, trig_rising;
	logic ext_start_in, ext_start_en, ext_start_rising;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, conv_data, rd_val;
	logic [2:0] conv_channel;
	logic [3:0] conv_gain;
	int n_mismatch, cmp_count, cyc;
	int q_t[$];
	logic [6:0] q_v[$];
	adc_start_scan_sequencer #(.FIFO_DEPTH(16), .CNT_W(16)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .trig_in(trig_in), .trig_en(trig_en),
		.trig_rising(trig_rising), .ext_start_in(ext_start_in),
		.ext_start_en(ext_start_en), .ext_start_rising(ext_start_rising),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_gain(conv_gain), .conv_done(conv_done),
		.conv_data(conv_data), .irq(irq));
	conv_model #(.DLY(3)) pm (.sys_clk(sys_clk), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_gain(conv_gain),
		.conv_done(conv_done), .conv_data(conv_data));
	// 200 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Log every start with its cycle, channel and gain
	always @(posedge sys_clk)
	begin
		if (conv_start === 1'b1)
		begin
			q_t.push_back(cyc);
			q_v.push_back({conv_channel, conv_gain});
		end
		cyc++;
	end
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		tick(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		tick(1);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		tick(1);
		rd_val = reg_rdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_val, e);
	endtask
	// Poll the sample count under a bound
	task automatic wait_count(input logic [31:0] n);
		for (int i = 0; i < 20; i++)
		begin
			rd(OFF_FIFO_COUNT);
			if (rd_val === n)
				return;
		end
		n_mismatch++;
		$display("MISMATCH %0t sample count stuck", $time);
		summarize;
	endtask
	task automatic t_regs;
		rdchk(OFF_CHAN_GAIN, RST_GAIN);
		rdchk(OFF_BASE_CLOCK, BASE_CLOCK_HZ);
		wr(OFF_CHAN_GAIN, 32'h00004321);
		rdchk(OFF_CHAN_GAIN, 32'h00004321);
		rdchk(8'h3C, 32'h00000000);
		wr(OFF_PERIOD_DIV, 32'h00000014);
		rdchk(OFF_PERIOD_DIV, 32'h00000014);
		wr(OFF_PERIOD_DIV, 32'h00000000);
	endtask
	// One start, one sample, popped through the data register
	task automatic t_single(input logic [31:0] c, input logic [6:0] v);
		q_t.delete();
		q_v.delete();
		wr(OFF_ACQ_CTRL, c);
		tick(40);
		chk(q_t.size(), 1);
		chk(q_v[0], v);
		wait_count(1);
		rdchk(OFF_FIFO_DATA, {25'h0000000, v});
		rdchk(OFF_FIFO_COUNT, 32'h00000000);
		wr(OFF_ACQ_CTRL, 32'h00000000);
	endtask
	// Advanced scan 0..3, restart attempt mid-scan, threshold interrupt
	task automatic t_scan;
		q_t.delete();
		q_v.delete();
		wr(OFF_SCAN_DIV, 32'h00000004);
		wr(OFF_FAF_THRESH, 32'h00000003);
		wr(OFF_IRQ, 32'h00000001);
		wr(OFF_ACQ_CTRL, 32'h00050230);
		wr(OFF_ACQ_CTRL, 32'h00050230);
		tick(40);
		chk(q_t.size(), 4);
		chk(irq, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			chk(q_t[i] - q_t[0], 4 * i);
			chk(q_v[i], 17 * i + 1);
			rdchk(OFF_FIFO_DATA, 17 * i + 1);
		end
		wr(OFF_IRQ, 32'h00000000);
		chk(irq, 1'b0);
		rdchk(OFF_IRQ, 32'h00010000);
		wr(OFF_IRQ, 32'h00010000);
		rdchk(OFF_IRQ, 32'h00000000);
		wr(OFF_ACQ_CTRL, 32'h00000000);
	endtask
	// Free-running or armed periodic starts, then stop
	task automatic t_periodic(input logic trig);
		int n;
		q_t.delete();
		trig_en = trig;
		wr(OFF_PERIOD_DIV, 32'h00000014);
		wr(OFF_ACQ_CTRL, 32'h00010010);
		if (trig)
		begin
			tick(40);
			chk(q_t.size(), 0);
			trig_in = 1'b1;
		end
		tick(70);
		chk(q_t.size() >= (trig ? 3 : 4), 1'b1);
		chk(q_t[1] - q_t[0], 20);
		chk(q_t[2] - q_t[1], 20);
		wr(OFF_ACQ_CTRL, 32'h00000000);
		n = q_t.size();
		tick(50);
		chk(q_t.size(), n);
		trig_en = 1'b0;
		trig_in = 1'b0;
	endtask
	// One start per selected edge, rising then falling
	task automatic t_ext;
		q_t.delete();
		q_v.delete();
		wr(OFF_PERIOD_DIV, 32'h00000000);
		wr(OFF_ACQ_CTRL, 32'h00000025);
		ext_start_en = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			tick(5);
			// Edge select moves only while the pin rests low
			ext_start_rising = (k == 0);
			ext_start_in = 1'b1;
			tick(5);
			ext_start_in = 1'b0;
		end
		tick(10);
		chk(q_t.size(), 2);
		chk(q_v[1], 7'h25);
		ext_start_en = 1'b0;
	endtask
	// Basic mode single starts walk 0, 1 and wrap, common gain
	task automatic t_rotate;
		q_v.delete();
		for (int i = 0; i < 3; i++)
			wr(OFF_ACQ_CTRL, 32'h00010316);
		tick(20);
		chk(q_v.size(), 3);
		chk(q_v[0], 7'h06);
		chk(q_v[1], 7'h16);
		chk(q_v[2], 7'h06);
		wr(OFF_ACQ_CTRL, 32'h00000000);
	endtask
	initial
	begin
		n_mismatch = 0;
		cmp_count = 0;
		cyc = 0;
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		trig_in = 1'b0;
		trig_en = 1'b0;
		trig_rising = 1'b1;
		ext_start_in = 1'b0;
		ext_start_en = 1'b0;
		ext_start_rising = 1'b1;
		repeat (10) @(posedge sys_clk);
		#1 resetn = 1'b1;
		t_regs;
		t_single(32'h00010053, 7'h53);
		t_single(32'h00050053, 7'h53);
		t_single(32'h00050200, 7'h01);
		t_scan;
		t_periodic(1'b0);
		t_periodic(1'b1);
		t_ext;
		t_rotate;
		summarize;
	end
endmodule
